// *** tb/hvw_switch_model.sv ***
// behavioural model of the switches and signal lines on the five wake pins
`timescale 1ns/1ps
module hvw_switch_model (
    input wire logic clk_i,
    input wire logic [4:0] pull_up_i,
    input wire logic [4:0] pull_down_i,
    output logic [4:0] pin_o
);
    logic [4:0] closed_r;
    logic [4:0] drv_r;
    logic [4:0] last_r;

    initial begin
        closed_r = 5'h1f;
        drv_r = 5'h00;
    end

    // ------------------------------------------------------------
    // line level
    // ------------------------------------------------------------
    // an open contact floats: only a current source defines it, otherwise it wanders off its last value
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin_o[i] = closed_r[i] ? drv_r[i] : pull_up_i[i] ? 1'b1 : pull_down_i[i] ? 1'b0 : ~last_r[i];
        end
    end

    always_ff @(posedge clk_i) begin
        last_r <= pin_o;
    end

    // changes happen just after an edge, like a real contact sampled by the comparator
    task automatic drive(input logic [4:0] closed, input logic [4:0] v);
        @(posedge clk_i);
        closed_r <= closed;
        drv_r <= v;
    endtask
endmodule

// *** tb/hvw_wake_top_test.sv ***
// self-checking bench for the high-voltage wake input logic
`timescale 1ns/1ps
module hvw_wake_top_test;
    import hvw_pkg::*;
    logic clk_i, rstn_i, cyc_window_i, fail_req_i, we_i, re_i;
    logic [4:0] wake_pin_i, addr_i, pull_up_o, pull_down_o, cur;
    logic [31:0] wdata_i, rdata_o, r;
    logic irq_o, wake_req_o, fail_output_on_o, sync_o;
    hvw_mode_e mode_i;
    int failures = 0;
    int tests_run = 0;

    hvw_wake_top hvw_wake_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .wake_pin_i(wake_pin_i), .mode_i(mode_i),
        .cyc_window_i(cyc_window_i), .fail_req_i(fail_req_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
        .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o), .wake_req_o(wake_req_o), .pull_up_o(pull_up_o),
        .pull_down_o(pull_down_o), .fail_output_on_o(fail_output_on_o), .sync_o(sync_o));
    hvw_switch_model hvw_switch_model_inst (.clk_i(clk_i), .pull_up_i(pull_up_o), .pull_down_i(pull_down_o),
        .pin_o(wake_pin_i));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    // read data is registered: it stands only in the cycle after the strobe
    task automatic chk_rd(input string what, input logic [4:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        chk(what, exp, rdata_o);
    endtask

    task automatic wait_hi(input string what, ref logic s, input int max);
        int n;
        n = 0;
        while (s !== 1'b1 && n < max) begin
            cycles(1);
            n++;
        end
        if (s !== 1'b1) begin
            failures++;
            $display("BAD %s expected 1 seen %b", what, s);
            conclude();
        end
    endtask

    task automatic pins(input logic [4:0] v);
        cur = v;
        hvw_switch_model_inst.drive(5'h1f, v);
    endtask

    function automatic logic [9:0] exp_pull(input logic [7:0] code, input logic [4:0] lvl);
        logic [4:0] pu;
        logic [4:0] pd;
        pu = 5'h10;
        pd = 5'h00;
        for (int i = 0; i < 4; i++) begin
            case (code[2*i +: 2])
                PULL_DOWN: pd[i] = 1'b1;
                PULL_UP: pu[i] = 1'b1;
                PULL_AUTO: begin
                    pu[i] = lvl[i];
                    pd[i] = ~lvl[i];
                end
                default: ;
            endcase
        end
        return {pu, pd};
    endfunction

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        rstn_i = 1'b0;
        cyc_window_i = 1'b0;
        fail_req_i = 1'b1;
        we_i = 1'b0;
        re_i = 1'b0;
        addr_i = 5'h00;
        wdata_i = 32'h0;
        mode_i = HVW_INIT;
        cur = 5'h00;
        void'($urandom(32'h2476));
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        cycles(2);
        chk("pull outputs", 32'h200, {22'h0, pull_up_o, pull_down_o});
        chk("fail output", 32'h1, {31'h0, fail_output_on_o});
        fail_req_i <= 1'b0;
        cycles(2);
        chk("fail output idle", 32'h0, {31'h0, fail_output_on_o});
        fail_req_i <= 1'b1;
        chk_rd("control", A_CTRL, 32'h200);
        chk_rd("pull select", A_PULL, 32'h0);
        chk_rd("unmapped", 5'h1c, 32'h0);
        r = $urandom & 32'h3ff;
        wr(A_FILT, r);
        chk_rd("filter select", A_FILT, r);
        wr(A_FILT, 32'h0);
        pins(5'h02);
        cycles(6);
        chk_rd("fail pin level", A_LVL, 32'h0);
        $display("test reset done");

        pins(5'h01);
        wr(A_IEN, 32'h1f);
        wr(A_CTRL, 32'h037);
        cycles(500);
        chk("fail output", 32'h0, {31'h0, fail_output_on_o});
        chk("irq in init", 32'h0, {31'h0, irq_o});
        chk_rd("status", A_STAT, 32'h01);
        chk_rd("level", A_LVL, 32'h01);
        wr(A_CLR, 32'h3f);
        chk_rd("cleared in init", A_STAT, 32'h0);
        mode_i <= HVW_NORMAL;
        wait_hi("irq", irq_o, 4);
        chk_rd("init flag", A_STAT, 32'h01);
        wr(A_CLR, 32'h3f);
        cycles(3);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        $display("test init to normal done");

        pins(5'h05);
        cycles(100);
        pins(5'h01);
        cycles(500);
        chk_rd("glitch status", A_STAT, 32'h0);
        pins(5'h00);
        cycles(300);
        chk_rd("early status", A_STAT, 32'h0);
        wait_hi("irq", irq_o, 200);
        chk_rd("falling status", A_STAT, 32'h01);
        wr(A_CLR, 32'h3f);
        $display("test filter done");

        wr(A_CTRL, 32'h033);
        pins(5'h04);
        cycles(500);
        chk_rd("disabled status", A_STAT, 32'h0);
        chk("disabled irq", 32'h0, {31'h0, irq_o});
        chk_rd("disabled level", A_LVL, 32'h04);
        wr(A_CTRL, 32'h037);
        $display("test disable done");

        for (int k = 0; k < 6; k++) begin
            pins((k == 0) ? 5'h1f : 5'($urandom));
            r = (k == 0) ? 32'hff : $urandom & 32'hff;
            wr(A_PULL, r);
            cycles(6);
            chk_rd("level", A_LVL, {27'h0, cur});
            chk("pulls", {22'h0, exp_pull(r[7:0], cur)}, {22'h0, pull_up_o, pull_down_o});
        end
        wr(A_PULL, 32'h0);
        hvw_switch_model_inst.drive(5'h0f, cur);
        cycles(6);
        chk_rd("fixed pull level", A_LVL, {27'h0, 1'b1, cur[3:0]});
        pins(5'h00);
        cycles(500);
        wr(A_CLR, 32'h3f);
        $display("test pulls done");

        mode_i <= HVW_SLEEP;
        pins(5'h01);
        wait_hi("wake request", wake_req_o, 600);
        chk("irq in sleep", 32'h0, {31'h0, irq_o});
        mode_i <= HVW_NORMAL;
        wr(A_CLR, 32'h3f);
        wr(A_CTRL, 32'h237);
        chk_rd("locked control", A_CTRL, 32'h037);
        chk_rd("lock flag", A_STAT, 32'h20);
        wr(A_CLR, 32'h3f);
        $display("test sleep and lock done");

        wr(A_CTRL, 32'h057);
        pins(5'h09);
        cycles(6);
        chk("sync", {31'h0, cur[3]}, {31'h0, sync_o});
        chk_rd("sync level", A_LVL, 32'h01);
        cycles(500);
        chk_rd("sync status", A_STAT, 32'h0);
        $display("test sync done");

        wr(A_CTRL, 32'h137);
        cyc_window_i <= 1'b1;
        cycles(6);
        cyc_window_i <= 1'b0;
        cycles(2);
        pins(5'h08);
        cycles(500);
        chk_rd("cyclic level", A_LVL, 32'h09);
        chk_rd("cyclic status", A_STAT, 32'h0);
        $display("test cyclic done");
        rstn_i <= 1'b0;
        cycles(3);
        rstn_i <= 1'b1;
        cycles(2);
        chk("fail output after reset", 32'h1, {31'h0, fail_output_on_o});
        chk_rd("control after reset", A_CTRL, 32'h200);
        chk_rd("status after reset", A_STAT, 32'h0);
        $display("test second reset done");
        conclude();
    end
endmodule

// *** verilog/hvw_pkg.sv ***
// constants and types shared by the high-voltage wake input logic
package hvw_pkg;

    // ------------------------------------------------------------
    // geometry and clock
    // ------------------------------------------------------------
    localparam int NPIN = 5;
    localparam int CLK_MHZ = 25;
    localparam int FILT_CNT_W = 12;

    // pin roles, zero based
    localparam int PIN_FO = 1;
    localparam int PIN_SYNC = 3;
    localparam int PIN_FIXPU = 4;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_PULL = 5'h04;
    localparam logic [4:0] A_FILT = 5'h08;
    localparam logic [4:0] A_STAT = 5'h0c;
    localparam logic [4:0] A_CLR = 5'h10;
    localparam logic [4:0] A_IEN = 5'h14;
    localparam logic [4:0] A_LVL = 5'h18;

    // ------------------------------------------------------------
    // wake_control fields
    // ------------------------------------------------------------
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_SEL4_LSB = 5;
    localparam int CTRL_CYC_BIT = 8;
    localparam int CTRL_FO_BIT = 9;
    localparam logic [9:0] CTRL_WMASK = 10'h377;
    localparam logic [9:0] CTRL_RST = 10'h200;
    localparam logic [9:0] PULL_WMASK = 10'h0ff;
    localparam logic [9:0] PULL_RST = 10'h000;
    localparam logic [9:0] FILT_RST = 10'h000;

    // fourth pin role select
    localparam logic [1:0] SEL4_OFF = 2'h0;
    localparam logic [1:0] SEL4_WAKE = 2'h1;
    localparam logic [1:0] SEL4_SYNC = 2'h2;

    // pull select codes, hi bit then lo bit
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;

    // filter times in microseconds, one per filter select code
    localparam int FILT_US [4] = '{16, 32, 64, 128};

    // status layout: wake events in 4..0, lock violation above
    localparam int STAT_W = 6;
    localparam int STAT_LOCK_BIT = 5;

    typedef enum logic [2:0] {
        HVW_INIT,
        HVW_NORMAL,
        HVW_STOP,
        HVW_SLEEP,
        HVW_FAILSAFE
    } hvw_mode_e;

endpackage

// *** verilog/hvw_pull.sv ***
// current source steering for one wake pin
`timescale 1ns/1ps
module hvw_pull #(
    parameter bit FIXED_PU = 1'b0
) (
    input logic clk_i,
    input logic rstn_i,
    input logic [1:0] sel_i,
    input logic lvl_i,
    output logic pu_o,
    output logic pd_o
);
    import hvw_pkg::*;

    logic pu_r;
    logic pd_r;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pu_r <= FIXED_PU;
            pd_r <= 1'b0;
        end else if (FIXED_PU) begin
            pu_r <= 1'b1;
            pd_r <= 1'b0;
        end else begin
            pu_r <= (sel_i == PULL_UP) || (sel_i == PULL_AUTO && lvl_i);
            pd_r <= (sel_i == PULL_DOWN) || (sel_i == PULL_AUTO && !lvl_i);
        end
    end

    assign pu_o = pu_r;
    assign pd_o = pd_r;
endmodule

// *** verilog/hvw_wake_chan.sv ***
// one wake channel: pin synchroniser and edge filter
`timescale 1ns/1ps
module hvw_wake_chan #(
    parameter int CNT_W = 12
) (
    input logic clk_i,
    input logic rstn_i,
    input logic pin_i,
    input logic [CNT_W-1:0] limit_i,
    input logic run_i,
    output logic lvl_sync_o,
    output logic lvl_o,
    output logic edge_o
);
    logic meta_r;
    logic sync_r;
    logic stable_r;
    logic edge_r;
    logic [CNT_W-1:0] cnt_r;

    // two flops before anything looks at the comparator
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
        end
    end

    // stored level starts low, so a high pin after reset counts as an edge
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            stable_r <= 1'b0;
            edge_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            edge_r <= 1'b0;
            if (!run_i || sync_r == stable_r) begin
                cnt_r <= '0;
            end else if (cnt_r >= limit_i - CNT_W'(1)) begin
                stable_r <= sync_r;
                edge_r <= 1'b1;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + CNT_W'(1);
            end
        end
    end

    assign lvl_sync_o = sync_r;
    assign lvl_o = stable_r;
    assign edge_o = edge_r;
endmodule

// *** verilog/hvw_wake_top.sv ***
// high-voltage wake input logic: filters, status, level readback, pulls
//
// Notes on behaviour
// - each wake pin reports both rising and falling filtered transitions.
// - an edge raises the interrupt in normal or stop, wakes in sleep or fail-safe.
// - software picks static or cyclic sensing; static keeps inputs always live.
// - cyclic sensing evaluates a pin only inside the active window.
// - a crossing starts the filter; crossing back before expiry cancels it.
// - each wake pin has its own enable bit, except the fourth, which is enabled by its role select code.
// - accepted wake events are latched in a readable event status register.
// - level status shows pin levels in normal, stop and init modes.
// - in cyclic sensing level status shows the last window's sampled level.
// - no level readback for the sync-input pin or the fail-output pin.
// - pull code 00 none, 01 down, 10 up, 11 automatic.
// - automatic pull follows the detected level: up when high, down when low.
// - the fifth pin has a fixed pull-up and no pull select.
// - each pin has a filter select used in both sensing schemes.
// - init to normal in static sensing flags pins already high.
// - fourth pin as sync input ignores its wake settings, no wake at all.
// - second pin is the fail output after reset until reconfigured.
`timescale 1ns/1ps
module hvw_wake_top (
    input logic clk_i,
    input logic rstn_i,
    input logic [hvw_pkg::NPIN-1:0] wake_pin_i,
    input hvw_pkg::hvw_mode_e mode_i,
    input logic cyc_window_i,
    input logic fail_req_i,
    input logic [4:0] addr_i,
    input logic [31:0] wdata_i,
    input logic we_i,
    input logic re_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    output logic wake_req_o,
    output logic [hvw_pkg::NPIN-1:0] pull_up_o,
    output logic [hvw_pkg::NPIN-1:0] pull_down_o,
    output logic fail_output_on_o,
    output logic sync_o
);
    import hvw_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [9:0] ctrl_r;
    logic [9:0] pull_r;
    logic [9:0] filt_r;
    logic [STAT_W-1:0] stat_r;
    logic [STAT_W-1:0] stat_nxt;
    logic [STAT_W-1:0] ien_r;
    logic [NPIN-1:0] cyc_lvl_r;
    logic fo_lock_r;
    hvw_mode_e mode_prev_r;
    logic [31:0] rdata_r;
    logic irq_r;
    logic wake_req_r;
    logic sync_r;
    logic fail_on_r;

    logic [NPIN-1:0] lvl_sync_w;
    logic [NPIN-1:0] lvl_w;
    logic [NPIN-1:0] edge_w;
    logic [NPIN-1:0] en_eff_w;
    logic [NPIN-1:0] lvl_ok_w;
    logic [NPIN-1:0] init_hit_w;
    logic [NPIN-1:0] ev_w;
    logic [NPIN-1:0] lvl_stat_w;
    logic [1:0] sel4_w;
    logic cyc_w;
    logic fo_mode_w;
    logic run_w;
    logic ctrl_wr_w;
    logic lock_err_w;
    logic [STAT_W-1:0] set_w;
    logic [STAT_W-1:0] clr_w;
    logic to_normal_w;
    logic lvl_vis_w;
    logic diff0_w;

    assign sel4_w = ctrl_r[CTRL_SEL4_LSB +: 2];
    assign cyc_w = ctrl_r[CTRL_CYC_BIT];
    assign fo_mode_w = ctrl_r[CTRL_FO_BIT];
    // outside the window the cyclic filters freeze and drop partial counts
    assign run_w = !cyc_w || cyc_window_i;
    assign to_normal_w = (mode_prev_r == HVW_INIT) && (mode_i == HVW_NORMAL) && !cyc_w;
    assign lvl_vis_w = (mode_i == HVW_NORMAL) || (mode_i == HVW_STOP) || (mode_i == HVW_INIT);
    // pin 0 stands in for every channel in the filter checks below
    assign diff0_w = lvl_sync_w[0] != lvl_w[0];

    // ------------------------------------------------------------
    // per pin channels
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            logic [FILT_CNT_W-1:0] limit_w;
            assign limit_w = FILT_CNT_W'(FILT_US[filt_r[2*gi +: 2]] * CLK_MHZ);

            hvw_wake_chan #(
                .CNT_W(FILT_CNT_W)
            ) u_chan (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .pin_i(wake_pin_i[gi]),
                .limit_i(limit_w),
                .run_i(run_w),
                .lvl_sync_o(lvl_sync_w[gi]),
                .lvl_o(lvl_w[gi]),
                .edge_o(edge_w[gi])
            );

            hvw_pull #(
                .FIXED_PU(gi == PIN_FIXPU)
            ) u_pull (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .sel_i(pull_r[2*gi +: 2]),
                .lvl_i(lvl_sync_w[gi]),
                .pu_o(pull_up_o[gi]),
                .pd_o(pull_down_o[gi])
            );

            if (gi == PIN_SYNC) begin : g_sync
                assign en_eff_w[gi] = (sel4_w == SEL4_WAKE);
                assign lvl_ok_w[gi] = (sel4_w != SEL4_SYNC);
            end else if (gi == PIN_FO) begin : g_fo
                assign en_eff_w[gi] = ctrl_r[CTRL_EN_LSB + gi] && !fo_mode_w;
                assign lvl_ok_w[gi] = !fo_mode_w;
            end else begin : g_plain
                assign en_eff_w[gi] = ctrl_r[CTRL_EN_LSB + gi];
                assign lvl_ok_w[gi] = 1'b1;
            end

            assign init_hit_w[gi] = to_normal_w && en_eff_w[gi] && lvl_w[gi];
            assign ev_w[gi] = (edge_w[gi] && en_eff_w[gi]) || init_hit_w[gi];
            assign lvl_stat_w[gi] = lvl_vis_w && lvl_ok_w[gi]
                && (cyc_w ? cyc_lvl_r[gi] : lvl_sync_w[gi]);
        end
    endgenerate

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    assign ctrl_wr_w = we_i && (addr_i == A_CTRL);
    // the fail-output choice is fixed by the first control write; a later change is refused
    assign lock_err_w = ctrl_wr_w && fo_lock_r && (wdata_i[CTRL_FO_BIT] != fo_mode_w);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl_r <= CTRL_RST;
            fo_lock_r <= 1'b0;
        end else if (ctrl_wr_w) begin
            fo_lock_r <= 1'b1;
            ctrl_r <= wdata_i[9:0] & CTRL_WMASK;
            if (fo_lock_r) begin
                ctrl_r[CTRL_FO_BIT] <= fo_mode_w;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pull_r <= PULL_RST;
            filt_r <= FILT_RST;
            ien_r <= '0;
        end else if (we_i) begin
            if (addr_i == A_PULL) begin
                pull_r <= wdata_i[9:0] & PULL_WMASK;
            end else if (addr_i == A_FILT) begin
                filt_r <= wdata_i[9:0];
            end else if (addr_i == A_IEN) begin
                ien_r <= wdata_i[STAT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // event status, set wins over clear
    // ------------------------------------------------------------
    assign set_w = {lock_err_w, ev_w};
    assign clr_w = (we_i && addr_i == A_CLR) ? wdata_i[STAT_W-1:0] : '0;
    assign stat_nxt = (stat_r & ~clr_w) | set_w;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            stat_r <= '0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // ------------------------------------------------------------
    // cyclic level capture and mode history
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cyc_lvl_r <= '0;
        end else if (cyc_window_i) begin
            cyc_lvl_r <= lvl_sync_w;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            mode_prev_r <= HVW_INIT;
        end else begin
            mode_prev_r <= mode_i;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_r <= 1'b0;
            wake_req_r <= 1'b0;
        end else begin
            irq_r <= |(stat_nxt & ien_r) && (mode_i == HVW_NORMAL || mode_i == HVW_STOP);
            wake_req_r <= |ev_w && (mode_i == HVW_SLEEP || mode_i == HVW_FAILSAFE);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sync_r <= 1'b0;
            fail_on_r <= 1'b0;
        end else begin
            sync_r <= (sel4_w == SEL4_SYNC) && lvl_sync_w[PIN_SYNC];
            fail_on_r <= fo_mode_w && fail_req_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_r <= '0;
        end else if (!re_i) begin
            rdata_r <= '0;
        end else if (addr_i == A_CTRL) begin
            rdata_r <= {22'h0, ctrl_r};
        end else if (addr_i == A_PULL) begin
            rdata_r <= {22'h0, pull_r};
        end else if (addr_i == A_FILT) begin
            rdata_r <= {22'h0, filt_r};
        end else if (addr_i == A_STAT) begin
            rdata_r <= {26'h0, stat_r};
        end else if (addr_i == A_IEN) begin
            rdata_r <= {26'h0, ien_r};
        end else if (addr_i == A_LVL) begin
            rdata_r <= {27'h0, lvl_stat_w};
        end else begin
            rdata_r <= '0;
        end
    end

    assign rdata_o = rdata_r;
    assign irq_o = irq_r;
    assign wake_req_o = wake_req_r;
    assign fail_output_on_o = fail_on_r;
    assign sync_o = sync_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_enter_normal;
        mode_i == HVW_INIT ##1 mode_i == HVW_NORMAL && !cyc_w;
    endsequence

    a_init_flag: assert property (
        (s_enter_normal ##0 (en_eff_w[0] && lvl_w[0])) |=> stat_r[0])
        else $error("pin high at init exit not flagged");

    a_event_sticky: assert property (
        (|ev_w) |=> ((stat_r & $past(set_w)) == $past(set_w)))
        else $error("wake event lost in status");

    a_irq_mode: assert property (
        irq_o |-> ($past(mode_i) == HVW_NORMAL || $past(mode_i) == HVW_STOP))
        else $error("interrupt outside normal or stop");

    a_wake_cause: assert property (
        wake_req_o |-> $past(|ev_w) && ($past(mode_i) == HVW_SLEEP || $past(mode_i) == HVW_FAILSAFE))
        else $error("wake request without event in low power mode");

    a_sync_no_wake: assert property (
        (sel4_w == SEL4_SYNC) |-> !ev_w[PIN_SYNC] && !lvl_stat_w[PIN_SYNC])
        else $error("sync pin produced wake or level");

    a_fo_no_level: assert property (
        fo_mode_w |-> !lvl_stat_w[PIN_FO] && !ev_w[PIN_FO])
        else $error("fail-output pin shows level or wake");

    a_disabled_quiet: assert property (
        (ev_w & ~en_eff_w) == '0)
        else $error("disabled pin raised a wake");

    a_cyc_idle: assert property (
        (cyc_w && !cyc_window_i) [*2] |-> edge_w == '0)
        else $error("edge accepted outside cyclic window");

    a_fixed_pullup: assert property (
        $rose(rstn_i) ##1 1'b1 |-> pull_up_o[PIN_FIXPU] && !pull_down_o[PIN_FIXPU])
        else $error("fifth pin lost its pull-up");

    a_auto_pull: assert property (
        (pull_r[1:0] == PULL_AUTO && lvl_sync_w[0]) [*2] |-> pull_up_o[0] && !pull_down_o[0])
        else $error("automatic pull does not follow high level");

    a_fo_locked: assert property (
        (fo_lock_r && ctrl_wr_w) |=> fo_mode_w == $past(fo_mode_w))
        else $error("fail-output selection changed after lock");

    a_fo_default: assert property (
        !fo_lock_r |-> fo_mode_w)
        else $error("second pin left fail output before any control write");

    sequence s_lock_write;
        fo_lock_r && ctrl_wr_w && (wdata_i[CTRL_FO_BIT] != fo_mode_w);
    endsequence

    a_lock_flag: assert property (
        s_lock_write |=> stat_r[STAT_LOCK_BIT])
        else $error("refused fail-output change not flagged");

    a_irq_level: assert property (
        irq_o == (|(stat_r & $past(ien_r)) && ($past(mode_i) == HVW_NORMAL || $past(mode_i) == HVW_STOP)))
        else $error("interrupt does not follow enabled status");

    a_status_sticky: assert property (
        ($past(stat_r) & ~stat_r & ~$past(clr_w)) == '0)
        else $error("status bit dropped without a clear");

    a_edge_level: assert property (
        edge_w[0] |-> lvl_w[0] != $past(lvl_w[0]) && lvl_w[0] == $past(lvl_sync_w[0]))
        else $error("accepted edge does not match pin level");

    a_filter_hold: assert property (
        edge_w[0] |-> $past(diff0_w, 2) && $past(diff0_w, 8))
        else $error("edge accepted before the filter time");
endmodule
